// [inc/osm_defines.svh]
// constants for the oscillator mode select block
`ifndef OSM_DEFINES_SVH
`define OSM_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// three-bit mode codes held in the configuration field
`define OSM_CODE_LOW_POWER_CRYSTAL   3'h0
`define OSM_CODE_STANDARD_CRYSTAL    3'h1
`define OSM_CODE_HIGH_SPEED_CRYSTAL  3'h2
`define OSM_CODE_MULTIPLIED_CRYSTAL  3'h6
`define OSM_CODE_RESISTOR_CAP        3'h3
`define OSM_CODE_RESISTOR_CAP_IO     3'h7
`define OSM_CODE_EXTERNAL_CLOCK      3'h4
`define OSM_CODE_EXTERNAL_CLOCK_IO   3'h5

////////////////////////////////////////////////////////////////////////////////
// timing: clock rate, lock timeout in us, external start-up in ns
`define OSM_CLK_HZ                   50000000
`define OSM_LOCK_TIMEOUT_US          2000
`define OSM_EXT_START_NS             1500
// lock timeout is a least time: round up
`define OSM_LOCK_CYCLES  ((`OSM_LOCK_TIMEOUT_US * (`OSM_CLK_HZ / 1000) + 999) / 1000)
// external start-up is a longest time: round down
`define OSM_EXT_START_CYCLES  ((`OSM_EXT_START_NS * (`OSM_CLK_HZ / 1000000)) / 1000)

////////////////////////////////////////////////////////////////////////////////
// clock-out divider ratio and reset values
`define OSM_DIV_RATIO                4
`define OSM_DIV_RESET                2'h0
`define OSM_PIN_RELEASED             1'h1

`endif

// [inc/osm_pkg.sv]
// types shared by the oscillator mode select block
package osm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// decoded function of one mode code
	typedef struct packed {
		logic drive_div4;   // clock-out pin shows clock divided by four
		logic port_io;      // clock-out pin serves as port bit six
		logic feedback_on;  // feedback element between the pins enabled
		logic mult_on;      // times-four multiplier selected
		logic ext_clock;    // external-clock mode, start-up limit applies
	} osm_decode_s;

	////////////////////////////////////////////////////////////////////////////
	// one pin seen from the device: driven value and active-low enable
	typedef struct packed {
		logic out;          // value driven onto the pin
		logic oe_n;         // low while the device drives the pin
	} osm_pin_s;

	////////////////////////////////////////////////////////////////////////////
	// start-up sequence states
	typedef enum logic [1:0] {
		OSM_ST_LATCH,
		OSM_ST_START,
		OSM_ST_LOCK,
		OSM_ST_RUN
	} osm_state_e;

endpackage : osm_pkg

// [logic/osm_div4.sv]
// clock divided by four for the clock-out pin
`timescale 1ns/1ns
`default_nettype none
`include "osm_defines.svh"

module osm_div4 (
	input  wire logic mclk,   // system clock
	input  wire logic nrst,   // synchronous reset, active low
	output var  logic q       // clock divided by four, registered
);

	logic [1:0] cnt;          // phase counter
	logic [1:0] next_cnt;     // next phase
	logic       next_q;       // next output level

	// elaboration check: the two-bit counter serves only a ratio of four
	if (`OSM_DIV_RATIO != 4) begin : g_chk
		$error("osm_div4 serves a ratio of four only");
	end

	////////////////////////////////////////////////////////////////////////////
	// next phase and output: high for two clocks, low for two
	always_comb begin
		next_cnt = cnt + 2'h1;
		next_q   = next_cnt[1];
	end

	// register phase and output
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt <= `OSM_DIV_RESET;
			q   <= 1'h0;
		end else begin
			cnt <= next_cnt;
			q   <= next_q;
		end
	end

endmodule : osm_div4
`default_nettype wire

// [logic/osm_timer.sv]
// one-shot down-counter for start-up and lock timeouts
`timescale 1ns/1ns
`default_nettype none

module osm_timer #(
	parameter int CYCLES = 75                  // cycles from start to done
) (
	input  wire logic mclk,                    // system clock
	input  wire logic nrst,                    // synchronous reset, active low
	input  wire logic start,                   // one-cycle pulse, (re)loads the count
	output var  logic done                     // level, high once the count has run out
);

	localparam int W = $clog2(CYCLES + 1);    // counter width

	logic [W-1:0] cnt;                         // remaining cycles
	logic [W-1:0] next_cnt;                    // next remaining cycles
	logic         next_done;                   // next done level

	// elaboration check: at least one cycle
	if (CYCLES < 1) begin : g_chk
		$error("osm_timer needs CYCLES of one or more");
	end

	////////////////////////////////////////////////////////////////////////////
	// load on start, count down, raise done on the last step
	always_comb begin
		next_cnt  = cnt;
		next_done = done;
		if (start) begin
			next_cnt  = W'(CYCLES);
			next_done = 1'h0;
		end else if (cnt != '0) begin
			next_cnt  = cnt - W'(1);
			next_done = (cnt == W'(1));
		end
	end

	// register count and done
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt  <= '0;
			done <= 1'h0;
		end else begin
			cnt  <= next_cnt;
			done <= next_done;
		end
	end

endmodule : osm_timer
`default_nettype wire

// [logic/osm_top.sv]
// oscillator mode select: mode decode, clock-out pin, multiplier enable, start-up hold
`timescale 1ns/1ns
`default_nettype none
`include "osm_defines.svh"

module osm_top #(
	parameter int LOCK_CYCLES  = `OSM_LOCK_CYCLES,      // multiplier lock timeout in cycles
	parameter int START_CYCLES = `OSM_EXT_START_CYCLES  // external-clock start-up in cycles
) (
	input  wire logic       mclk,                   // selected system clock, 50 MHz
	input  wire logic       nrst,                   // power-on reset, synchronous, active low
	input  wire logic [2:0] mode_cfg,               // nonvolatile mode field, static
	input  wire logic       wake,                   // one-cycle pulse, wake-up from sleep
	input  wire logic       sec_osc_sel,            // level, secondary oscillator is system clock
	input  wire logic       port_bit_six_out,       // port logic value for bit six
	input  wire logic       port_bit_six_oe_n,      // port logic enable for bit six, active low
	output var  logic       port_bit_six_in,        // pin level seen by port bit six
	input  wire logic       clock_out_pin_in,       // clock-out pin level
	output var  logic       clock_out_pin_out,      // clock-out pin driven value
	output var  logic       clock_out_pin_oe_n,     // clock-out pin enable, low drives
	output var  logic       feedback_en,            // feedback element between pins on
	output var  logic       mult_en,                // times-four multiplier enabled
	output var  logic       ext_clock_sel,          // system clock taken straight from input pin
	output var  logic       cpu_run,                // instruction execution allowed
	output var  logic [2:0] mode_code               // mode in force, registered
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks on the timing parameters
	if (LOCK_CYCLES < 1) begin : g_chk_lock
		$error("osm_top needs LOCK_CYCLES of one or more");
	end
	if (START_CYCLES < 1) begin : g_chk_start
		$error("osm_top needs START_CYCLES of one or more");
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [2:0]          mode;                     // latched mode code
	logic [2:0]          next_mode;                // next mode code
	osm_pkg::osm_decode_s dec;                     // decoded functions of the mode
	osm_pkg::osm_state_e  state;                   // start-up sequence state
	osm_pkg::osm_state_e  next_state;              // next start-up state
	logic                mult;                     // multiplier enable in force
	logic                next_mult;                // next multiplier enable
	logic                sec_prev;                 // secondary select, last cycle
	logic                next_sec_prev;            // next secondary select copy
	logic                wake_prev;                // wake seen while running in an external-clock mode
	logic                start_go;                 // start external start-up timer
	logic                lock_go;                  // start lock timer
	logic                start_done;               // start-up timer has run out
	logic                lock_done;                // lock timer has run out
	logic                div4;                     // clock divided by four
	osm_pkg::osm_pin_s   pin;                      // clock-out pin drive
	osm_pkg::osm_pin_s   next_pin;                 // next clock-out pin drive
	logic                back_to_main;             // return from secondary oscillator

	////////////////////////////////////////////////////////////////////////////
	// mode decode
	// fixed code decode
	always_comb begin
		dec = '0;
		case (mode)
			// crystal modes: pin belongs to the oscillator, feedback on
			// crystal or driven clock
			`OSM_CODE_LOW_POWER_CRYSTAL: begin
				dec.feedback_on = 1'h1;
			end
			`OSM_CODE_STANDARD_CRYSTAL: begin
				dec.feedback_on = 1'h1;
			end
			`OSM_CODE_HIGH_SPEED_CRYSTAL: begin
				dec.feedback_on = 1'h1;
			end
			`OSM_CODE_MULTIPLIED_CRYSTAL: begin
				dec.feedback_on = 1'h1;
				dec.mult_on     = 1'h1;
			end
			`OSM_CODE_RESISTOR_CAP: begin
				dec.drive_div4 = 1'h1;
			end
			`OSM_CODE_RESISTOR_CAP_IO: begin
				dec.port_io = 1'h1;
			end
			`OSM_CODE_EXTERNAL_CLOCK: begin
				dec.drive_div4 = 1'h1;
				dec.ext_clock  = 1'h1;
			end
			`OSM_CODE_EXTERNAL_CLOCK_IO: begin
				dec.port_io   = 1'h1;
				dec.ext_clock = 1'h1;
			end
			// all eight codes are covered above
			default: begin
				dec = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// mode latch: the field is sampled only while reset is held
	// mode fixed after reset
	always_comb begin
		next_mode = mode;
	end

	// register the mode; the field is read only under reset
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mode <= mode_cfg;
		end else begin
			mode <= next_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// multiplier enable: reload in the latch state and on return from the secondary oscillator
	always_comb begin
		back_to_main  = sec_prev && !sec_osc_sel;
		next_sec_prev = sec_osc_sel;
		next_mult     = mult;
		if (state == osm_pkg::OSM_ST_LATCH) begin
			next_mult = dec.mult_on;
		end else if (back_to_main) begin
			next_mult = dec.mult_on;
		end else if (sec_osc_sel) begin
			// multiplier idles while the secondary source runs the system
			next_mult = 1'h0;
		end
	end

	// register multiplier enable and secondary select copy
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mult     <= 1'h0;
			sec_prev <= 1'h0;
		end else begin
			mult     <= next_mult;
			sec_prev <= next_sec_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// start-up sequence: latch, optional start-up or lock wait, run
	always_comb begin
		next_state = state;
		start_go   = 1'h0;
		lock_go    = 1'h0;
		wake_prev  = 1'h0;
		case (state)
			// first cycle after release: pick the wait that the mode needs
			osm_pkg::OSM_ST_LATCH: begin
				if (dec.mult_on) begin
					lock_go    = 1'h1;
					next_state = osm_pkg::OSM_ST_LOCK;
				end else if (dec.ext_clock) begin
					start_go   = 1'h1;
					next_state = osm_pkg::OSM_ST_START;
				end else begin
					next_state = osm_pkg::OSM_ST_RUN;
				end
			end
			osm_pkg::OSM_ST_START: begin
				if (start_done) begin
					next_state = osm_pkg::OSM_ST_RUN;
				end
			end
			osm_pkg::OSM_ST_LOCK: begin
				if (lock_done) begin
					next_state = osm_pkg::OSM_ST_RUN;
				end
			end
			// running: wake-up in an external-clock mode or a return to the main source in the multiplier mode restarts a wait
			osm_pkg::OSM_ST_RUN: begin
				if (wake && dec.ext_clock) begin
					wake_prev  = 1'h1;
					start_go   = 1'h1;
					next_state = osm_pkg::OSM_ST_START;
				end else if (back_to_main && dec.mult_on) begin
					lock_go    = 1'h1;
					next_state = osm_pkg::OSM_ST_LOCK;
				end
			end
			// unreachable codes fall back to the latch state
			default: begin
				next_state = osm_pkg::OSM_ST_LATCH;
			end
		endcase
	end

	// register the sequence state
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state <= osm_pkg::OSM_ST_LATCH;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timers
	// start-up timer
	osm_timer #(
		.CYCLES (START_CYCLES)
	) u_start (
		.mclk  (mclk),
		.nrst  (nrst),
		.start (start_go),
		.done  (start_done)
	);

	osm_timer #(
		.CYCLES (LOCK_CYCLES)
	) u_lock (
		.mclk  (mclk),
		.nrst  (nrst),
		.start (lock_go),
		.done  (lock_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// divided clock for the clock-out pin
	osm_div4 u_div4 (
		.mclk (mclk),
		.nrst (nrst),
		.q    (div4)
	);

	////////////////////////////////////////////////////////////////////////////
	// clock-out pin drive
	always_comb begin
		next_pin.out  = 1'h0;
		next_pin.oe_n = `OSM_PIN_RELEASED;
		if (state == osm_pkg::OSM_ST_LATCH) begin
			// released until the mode is known
			next_pin.oe_n = `OSM_PIN_RELEASED;
		end else if (dec.drive_div4) begin
			next_pin.out  = next_div4_level(div4);
			next_pin.oe_n = 1'h0;
		end else if (dec.port_io) begin
			next_pin.out  = port_bit_six_out;
			next_pin.oe_n = port_bit_six_oe_n;
		end
	end

	// the divided clock is already registered; pass its level through
	function automatic logic next_div4_level(input logic lvl);
		next_div4_level = lvl;
	endfunction : next_div4_level

	// register the pin drive so the pin outputs come from flip-flops
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pin.out  <= 1'h0;
			pin.oe_n <= `OSM_PIN_RELEASED;
		end else begin
			pin <= next_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign clock_out_pin_out  = pin.out;
	assign clock_out_pin_oe_n = pin.oe_n;
	assign port_bit_six_in    = dec.port_io ? clock_out_pin_in : 1'h0;
	assign feedback_en        = (state != osm_pkg::OSM_ST_LATCH) && dec.feedback_on;
	assign mult_en            = mult;
	assign ext_clock_sel      = !mult;
	assign cpu_run            = (state == osm_pkg::OSM_ST_RUN) && !wake_prev;
	assign mode_code          = mode;

endmodule : osm_top
`default_nettype wire

// [test/osm_props.sv]
// checker for the oscillator mode select block
`timescale 1ns/1ns
`default_nettype none
`include "osm_defines.svh"

module osm_props #(
	parameter int LOCK_CYCLES  = 20, // lock hold
	parameter int START_CYCLES = 5   // ext start-up
) (
	input wire logic       mclk,               // clock
	input wire logic       nrst,               // reset
	input wire logic       wake,               // wake pulse
	input wire logic       sec_osc_sel,        // secondary on
	input wire logic       clock_out_pin_in,   // pin level
	input wire logic       port_bit_six_in,    // port view
	input wire logic       clock_out_pin_out,  // pin value
	input wire logic       clock_out_pin_oe_n, // pin enable
	input wire logic       feedback_en,        // feedback
	input wire logic       mult_en,            // multiplier
	input wire logic       ext_clock_sel,      // direct clock
	input wire logic       cpu_run,            // execution
	input wire logic [2:0] mode_code           // mode
);
	localparam int START_LIM = START_CYCLES + 2; // start-up bound
	localparam int LOCK_LIM  = LOCK_CYCLES + 3;  // lock bound
	logic [7:0] rel_cnt;      // edges since release
	logic [7:0] next_rel_cnt; // next count
	logic       ext;          // external modes
	logic       io;           // port bit modes
	logic       drv;          // divided clock modes
	logic       mul;          // multiplier mode
	assign ext = (mode_code == `OSM_CODE_EXTERNAL_CLOCK) || (mode_code == `OSM_CODE_EXTERNAL_CLOCK_IO);
	assign io  = (mode_code == `OSM_CODE_RESISTOR_CAP_IO) || (mode_code == `OSM_CODE_EXTERNAL_CLOCK_IO);
	assign drv = (mode_code == `OSM_CODE_RESISTOR_CAP) || (mode_code == `OSM_CODE_EXTERNAL_CLOCK);
	assign mul = (mode_code == `OSM_CODE_MULTIPLIED_CRYSTAL);

	////////////////////////////////////////////////////////////////////////////
	// saturating count of edges since reset release
	always_comb begin
		next_rel_cnt = (rel_cnt == 8'hFF) ? rel_cnt : rel_cnt + 8'h01;
		if (!nrst) begin
			next_rel_cnt = 8'h00;
		end
	end
	always_ff @(posedge mclk) begin
		rel_cnt <= next_rel_cnt;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_MULT_ONLY_FAST: assert property (mult_en |-> mul)
		else $error("multiplier on outside its mode");
	AST_CLOCK_PATH: assert property (ext_clock_sel == !mult_en)
		else $error("clock path disagrees with multiplier");
	AST_FEEDBACK_OFF: assert property ((ext || drv || io) |-> !feedback_en)
		else $error("feedback on in a non-crystal mode");
	AST_IO_PIN: assert property (io |-> port_bit_six_in == clock_out_pin_in)
		else $error("port bit six not fed from the pin");
	AST_DIV4_DRIVEN: assert property (drv && rel_cnt >= 8'h02 |-> !clock_out_pin_oe_n)
		else $error("divided clock not driven");
	AST_DIV4_SHAPE: assert property (
		drv && rel_cnt >= 8'h08 && $rose(clock_out_pin_out)
		|=> clock_out_pin_out ##1 !clock_out_pin_out [*2] ##1 clock_out_pin_out)
		else $error("divided clock shape wrong");
	AST_CRYSTAL_FREE: assert property (!(drv || io) |-> clock_out_pin_oe_n)
		else $error("pin driven in a crystal mode");
	AST_EXT_START: assert property (ext && $rose(nrst) |-> ##[1:START_LIM] cpu_run)
		else $error("external start-up too long");
	AST_WAKE_START: assert property (ext && wake |-> ##[1:START_LIM] cpu_run)
		else $error("wake start-up too long");
	AST_LOCK_HOLD: assert property (mul && rel_cnt < LOCK_CYCLES |-> !cpu_run)
		else $error("run before lock");
	AST_LOCK_DONE: assert property (mul && $rose(nrst) |-> ##[LOCK_CYCLES:LOCK_LIM] cpu_run)
		else $error("lock timeout wrong");
	AST_MULT_FROZEN: assert property (
		$changed(mult_en) |-> !$past(nrst, 2) || sec_osc_sel
		|| $past(sec_osc_sel) || $past(sec_osc_sel, 2))
		else $error("multiplier changed in operation");
	AST_MODE_HELD: assert property ($past(nrst) |-> $stable(mode_code))
		else $error("mode changed outside reset");

	cover property (ext && wake ##1 !cpu_run);
	cover property (mul && $rose(cpu_run));
	cover property (drv && $rose(clock_out_pin_out));
endmodule : osm_props

bind osm_top osm_props #(.LOCK_CYCLES(LOCK_CYCLES), .START_CYCLES(START_CYCLES)) u_props (
	.mclk(mclk), .nrst(nrst), .wake(wake), .sec_osc_sel(sec_osc_sel),
	.clock_out_pin_in(clock_out_pin_in), .port_bit_six_in(port_bit_six_in),
	.clock_out_pin_out(clock_out_pin_out), .clock_out_pin_oe_n(clock_out_pin_oe_n),
	.feedback_en(feedback_en), .mult_en(mult_en), .ext_clock_sel(ext_clock_sel),
	.cpu_run(cpu_run), .mode_code(mode_code));
`default_nettype wire

// [test/osm_far_end.sv]
// far-side model: source on clock-in, load on the clock-out pin
`timescale 1ns/1ns
`default_nettype none

module osm_far_end (
	input  wire logic osc_src,      // free-running source
	input  wire logic pin_out,      // device value on clock-out pin
	input  wire logic pin_oe_n,     // device enable, low drives
	input  wire logic ext_en,       // far side drives clock-out pin
	input  wire logic ext_val,      // value it drives
	output var  logic clock_in_pin, // clock into the device
	output var  logic pin_level     // resolved clock-out pin
);
	logic float_val = 1'b0; // changing level on an undriven pin

	// undriven pin never keeps its last value
	always @(posedge osc_src) begin
		float_val <= !float_val;
	end

	////////////////////////////////////////////////////////////////////////////
	// source drives clock-in
	always_comb begin
		clock_in_pin = osc_src;
	end

	always_comb begin
		pin_level = !pin_oe_n ? pin_out : (ext_en ? ext_val : float_val);
	end
endmodule : osm_far_end
`default_nettype wire

// [test/oscillator_mode_select_tb.sv]
// self-checking bench for the oscillator mode select block
`timescale 1ns/1ns
`default_nettype none
`include "osm_defines.svh"

module oscillator_mode_select_tb;
	localparam int LOCK  = 20; // shortened lock timeout
	localparam int START = 5;  // shortened start-up
	logic       osc = 1'b0;         // source oscillator
	logic       mclk;               // clock-in pin
	logic       nrst = 1'b0;        // reset
	logic [2:0] mode_cfg = 3'h0;    // mode field
	logic       wake = 1'b0;        // wake pulse
	logic       sec_osc_sel = 1'b0; // secondary select
	logic       pb_out = 1'b0;      // port value
	logic       pb_oe_n = 1'b1;     // port enable
	logic       ext_en = 1'b0;      // far side drives pin
	logic       ext_val = 1'b0;     // far side value
	logic       pb_in, pin_in, pin_out, pin_oe_n, fb, mult, run, xsel; // outputs
	logic [2:0] code;               // mode in force
	integer     seed = 32'hfb9e;    // random seed
	int         miscompares = 0;    // mismatches
	int         num_checks = 0;     // comparisons

	osm_far_end u_far (.osc_src(osc), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
		.ext_val(ext_val), .clock_in_pin(mclk), .pin_level(pin_in));
	osm_top #(.LOCK_CYCLES(LOCK), .START_CYCLES(START)) dut (.mclk(mclk), .nrst(nrst), .mode_cfg(mode_cfg),
		.wake(wake), .sec_osc_sel(sec_osc_sel), .port_bit_six_out(pb_out), .port_bit_six_oe_n(pb_oe_n),
		.port_bit_six_in(pb_in), .clock_out_pin_in(pin_in), .clock_out_pin_out(pin_out),
		.clock_out_pin_oe_n(pin_oe_n), .feedback_en(fb), .mult_en(mult), .ext_clock_sel(xsel),
		.cpu_run(run), .mode_code(code));

	// expected functions: {crystal, multiplier, divided clock, io, external}
	function automatic logic [4:0] expect_fn(input logic [2:0] c);
		logic mul;
		mul = (c == `OSM_CODE_MULTIPLIED_CRYSTAL);
		return {mul || c == `OSM_CODE_LOW_POWER_CRYSTAL || c == `OSM_CODE_STANDARD_CRYSTAL
			|| c == `OSM_CODE_HIGH_SPEED_CRYSTAL, mul, c == `OSM_CODE_RESISTOR_CAP
			|| c == `OSM_CODE_EXTERNAL_CLOCK, c == `OSM_CODE_RESISTOR_CAP_IO || c == `OSM_CODE_EXTERNAL_CLOCK_IO,
			c == `OSM_CODE_EXTERNAL_CLOCK || c == `OSM_CODE_EXTERNAL_CLOCK_IO};
	endfunction : expect_fn

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : tick

	// bounded wait for execution to start
	task automatic wait_run(input int lim, output int n);
		n = 0;
		while (run !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask : wait_run

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		forever #10 osc = ~osc;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// every code once, then random codes
	initial begin
		logic [2:0] c;
		logic [4:0] m;
		logic [7:0] s;
		int n;
		for (int i = 0; i < 12; i++) begin
			c = (i < 8) ? i[2:0] : 3'($random(seed));
			m = expect_fn(c);
			nrst = 1'b0;
			mode_cfg = c;
			pb_out = 1'($random(seed));
			pb_oe_n = 1'($random(seed));
			ext_en = 1'($random(seed));
			ext_val = 1'($random(seed));
			tick(20);
			nrst = 1'b1;
			tick(1);
			mode_cfg = ~c;
			check(code === c, "mode code");
			check(mult === m[3], "multiplier enable");
			wait_run(LOCK + START + 10, n);
			if (m[3]) check(n >= LOCK - 2 && n <= LOCK + 2, "lock wait");
			else check(n <= (m[0] ? START + 1 : 1), "start-up wait");
			tick(2);
			check(code === c, "mode held");
			check(fb === (m[4] && !m[0]), "feedback");
			if (m[1]) check(pin_oe_n === pb_oe_n && (pb_oe_n || pin_out === pb_out), "port pin drive");
			check(pb_in === (m[1] ? pin_in : 1'b0), "port bit six");
			check(xsel === !m[3], "clock path");
			// divided clock: period four, half high
			for (int k = 0; k < 8; k++) begin
				s[k] = pin_out;
				tick(1);
			end
			if (m[2]) check(pin_oe_n === 1'b0 && s[3:0] === s[7:4] && s[1:0] === ~s[3:2], "div4");
			wake = 1'b1;
			#1;
			check(run === !m[0], "wake hold");
			tick(1);
			wake = 1'b0;
			wait_run(START + 5, n);
			check(n <= START + 2, "wake start-up");
			sec_osc_sel = 1'b1;
			tick(3);
			check(mult === 1'b0, "multiplier off on secondary");
			sec_osc_sel = 1'b0;
			tick(2);
			check(mult === m[3] && run === !m[3], "return");
			wait_run(LOCK + 5, n);
			check(run === 1'b1, "run after return");
		end
		stop_test();
	end
endmodule : oscillator_mode_select_tb
`default_nettype wire
